//--- include/qbs_pkg.sv
// Package for the quad buck power sequencer: types, states and constants
package qbs_pkg;

  localparam int NUM_CH    = 4;
  localparam int NUM_SLOTS = 4;
  localparam int SLOT_W    = 2;

  // Timing: one slot is a programmable count of cycles
  localparam int          CLK_PERIOD_NS     = 100;
  localparam int          SLOT_TIME_NS      = 1000000;
  localparam int          SLOT_CYCLES_DFLT  = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SLOT_CNT_W        = 24;
  localparam logic [1:0]  MAX_START_SLOT    = 2'h2;
  localparam logic [1:0]  LAST_SLOT         = 2'h3;

  // Reset values
  localparam logic [3:0]  CH_EN_RST         = 4'h0;
  localparam logic        PGOOD_RST         = 1'b0;
  localparam logic        DISCH_RST         = 1'b0;
  localparam logic        OTWARN_RST        = 1'b0;
  localparam logic        THERM_LATCH_RST   = 1'b0;

  // Gray-coded states along power off, sequence on, on, sequence off
  typedef enum logic [1:0] {
    QBS_OFF     = 2'b00,
    QBS_SEQ_ON  = 2'b01,
    QBS_ON      = 2'b11,
    QBS_SEQ_OFF = 2'b10
  } qbs_state_t;

  // Synchronised analog comparator flags
  typedef struct packed {
    logic uv_fall;
    logic temp_120;
    logic temp_140;
    logic temp_160;
  } qbs_sense_t;

  // Per-channel enables and start slots, shared off mode and slot length, from the nonvolatile store
  typedef struct packed {
    logic [3:0]             ch_enable;
    logic [3:0][SLOT_W-1:0] ch_slot;
    logic                   staged_off;
    logic [SLOT_CNT_W-1:0]  slot_cycles;
  } qbs_cfg_t;

endpackage

//--- rtl/qbs_slot_timer.sv
// Slot tick divider: one-cycle pulse at the end of each delay slot
`timescale 1ns/1ps
module qbs_slot_timer (
  // Clock and reset
  input  wire logic                            i_clk_sys,
  input  wire logic                            i_reset_n,
  // Control
  input  wire logic                            i_run,
  input  wire logic [qbs_pkg::SLOT_CNT_W-1:0]  i_slot_cycles,
  // Tick
  output logic                                 o_tick
);
  import qbs_pkg::*;

  logic [SLOT_CNT_W-1:0] count;
  logic [SLOT_CNT_W-1:0] next_count;
  wire                   at_end;

  // A zero setting behaves as one cycle so slots never stall
  assign at_end     = (count + SLOT_CNT_W'(1) >= i_slot_cycles);
  assign next_count = (!i_run || at_end) ? '0 : count + SLOT_CNT_W'(1);
  assign o_tick     = i_run && at_end;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

//--- rtl/qbs_sequencer.sv
// Power control state machine for four buck channels
`timescale 1ns/1ps
module qbs_sequencer (
  // Clock and reset
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset_n,
  // Pins and sense flags
  input  wire logic               i_enable_sync_input_pin,
  input  wire qbs_pkg::qbs_sense_t i_sense,
  // Configuration
  input  wire qbs_pkg::qbs_cfg_t  i_cfg,
  // Outputs
  output logic [3:0]              o_ch_on,
  output logic                    o_power_good_output,
  output logic                    o_discharge,
  output logic                    o_overtemp_warning_flag,
  output logic                    o_thermal_shutdown,
  output qbs_pkg::qbs_state_t     o_state
);
  import qbs_pkg::*;

  qbs_state_t state;
  qbs_state_t next_state;
  logic [1:0] slot;
  logic [1:0] next_slot;
  logic [3:0] ch_on;
  logic [3:0] next_ch_on;
  logic       pgood;
  logic       therm_latch;
  logic       next_therm_latch;
  logic       disch;
  logic       otwarn;
  wire        tick;
  wire        timer_run;
  wire        fault;
  wire        therm_ok;
  wire [3:0]  on_mask;
  wire [3:0]  off_mask;
  wire        seq_on_done;
  wire        seq_off_done;

  assign timer_run = (state == QBS_SEQ_ON) || (state == QBS_SEQ_OFF);

  qbs_slot_timer u_timer (
    .i_clk_sys     (i_clk_sys),
    .i_reset_n     (i_reset_n),
    .i_run         (timer_run),
    .i_slot_cycles (i_cfg.slot_cycles),
    .o_tick        (tick)
  );

  // Clamp a slot setting above the allowed range to the last start slot
  function automatic logic [1:0] eff_slot(input logic [1:0] s);
    eff_slot = (s > MAX_START_SLOT) ? MAX_START_SLOT : s;
  endfunction

  // per-channel start and reverse-order stop masks
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign on_mask[g]  = i_cfg.ch_enable[g] && (eff_slot(i_cfg.ch_slot[g]) <= slot);
      // a channel in start slot k stops in off slot (2 - k)
      assign off_mask[g] = (MAX_START_SLOT - eff_slot(i_cfg.ch_slot[g])) <= slot;
    end
  endgenerate

  assign fault        = i_sense.uv_fall || i_sense.temp_160;
  assign therm_ok     = !i_sense.temp_140;
  // four slots make up the sequence
  assign seq_on_done  = tick && (slot == LAST_SLOT);
  assign seq_off_done = !i_cfg.staged_off || (tick && (slot == LAST_SLOT));

  always_comb begin
    next_state       = state;
    next_slot        = slot;
    next_ch_on       = ch_on;
    next_therm_latch = therm_latch;
    if (i_sense.temp_160) begin
      next_therm_latch = 1'b1;
    end else if (therm_ok) begin
      next_therm_latch = 1'b0;
    end
    unique case (state)
      QBS_OFF: begin
        next_ch_on = 4'h0;
        next_slot  = 2'h0;
        // thermal recovery waits on the latch
        if (i_enable_sync_input_pin && !fault && !therm_latch) begin
          next_state = QBS_SEQ_ON;
        end
      end
      QBS_SEQ_ON: begin
        if (fault || !i_enable_sync_input_pin) begin
          next_state = QBS_OFF;
          next_ch_on = 4'h0;
        end else begin
          next_ch_on = on_mask;
          if (tick) begin
            next_slot = slot + 2'h1;
          end
          if (seq_on_done) begin
            next_state = QBS_ON;
            next_slot  = 2'h0;
          end
        end
      end
      QBS_ON: begin
        if (fault) begin
          next_state = QBS_OFF;
          next_ch_on = 4'h0;
        // pin low begins power-off; channels stay on this cycle while power-good drops
        end else if (!i_enable_sync_input_pin) begin
          next_state = QBS_SEQ_OFF;
          next_slot  = 2'h0;
        end
      end
      QBS_SEQ_OFF: begin
        // enable pin not looked at here
        if (fault) begin
          next_state = QBS_OFF;
          next_ch_on = 4'h0;
        end else if (!i_cfg.staged_off) begin
          next_ch_on = 4'h0;
          next_state = QBS_OFF;
        end else begin
          next_ch_on = ch_on & ~off_mask;
          if (tick) begin
            next_slot = slot + 2'h1;
          end
          if (seq_off_done) begin
            next_state = QBS_OFF;
            next_ch_on = 4'h0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state       <= QBS_OFF;
      slot        <= 2'h0;
      ch_on       <= CH_EN_RST;
      therm_latch <= THERM_LATCH_RST;
    end else begin
      state       <= next_state;
      slot        <= next_slot;
      ch_on       <= next_ch_on;
      therm_latch <= next_therm_latch;
    end
  end

  // Flag registers; power-good only in full on state so it falls with the exit
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pgood  <= PGOOD_RST;
      disch  <= DISCH_RST;
      otwarn <= OTWARN_RST;
    end else begin
      // cleared as the on state is left
      pgood  <= (next_state == QBS_ON);
      disch  <= (next_state == QBS_SEQ_OFF) || (next_state == QBS_OFF);
      // warning follows the 120 C comparator
      otwarn <= i_sense.temp_120;
    end
  end

  assign o_ch_on                 = ch_on;
  assign o_power_good_output     = pgood;
  assign o_discharge             = disch;
  assign o_overtemp_warning_flag = otwarn;
  assign o_thermal_shutdown      = therm_latch;
  assign o_state                 = state;

  // channels never shrink while power-good is high; fault shutdown drops both at once
  a_pg_before_off: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_ch_on != $past(o_ch_on) && ($past(o_ch_on) & ~o_ch_on) != 4'h0 && !$past(fault))
      |-> !$past(o_power_good_output))
    else $error("channel turned off while power good high");

  // unstaged off clears all channels one cycle later
  a_off_all_once: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state == QBS_SEQ_OFF && !i_cfg.staged_off) |=> (o_ch_on == 4'h0 && state == QBS_OFF))
    else $error("unstaged power off not simultaneous");

  a_fault_kills_all: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (fault && state != QBS_OFF) |=> (o_ch_on == 4'h0 && state == QBS_OFF))
    else $error("fault did not shut all channels");

  // warning follows comparator by one cycle
  a_ot_warn_track: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    ##1 (o_overtemp_warning_flag == $past(i_sense.temp_120)))
    else $error("overtemp warning mismatch");

  a_therm_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state == QBS_OFF && therm_latch) |=> state == QBS_OFF)
    else $error("restart before hysteresis release");

  // pin low in on state enters sequence off
  a_pin_low_off: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state == QBS_ON && !fault && !i_enable_sync_input_pin) |=> (state == QBS_SEQ_OFF ##1 !o_power_good_output))
    else $error("pin low did not start power off");

  a_disch_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state == QBS_SEQ_OFF) |-> o_discharge)
    else $error("discharge dropped during power off");

  a_pg_in_on: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state == QBS_SEQ_ON && seq_on_done && !fault && i_enable_sync_input_pin) |=> (state == QBS_ON && o_power_good_output))
    else $error("power good missing after power on");

  // aborting power-on goes straight to off
  a_abort_on: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state == QBS_SEQ_ON && !i_enable_sync_input_pin) |=> (state == QBS_OFF && o_ch_on == 4'h0))
    else $error("power on abort failed");

  // a channel whose enable bit is clear never turns on
  a_on_gated: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (state != QBS_OFF) |-> ((o_ch_on & ~i_cfg.ch_enable) == 4'h0))
    else $error("disabled channel turned on");

  // 160 C trip sets the thermal latch on the next edge
  a_hot_latch: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_sense.temp_160 |=> o_thermal_shutdown)
    else $error("thermal latch not set by trip");

endmodule

//--- bench/qbs_rail_model.sv
// Four buck rails behind the sequencer: soft-start rise, fall only in discharge mode
`timescale 1ns/1ps
module qbs_rail_model #(
  parameter int RAMP = 2
) (
  // Clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  // From the sequencer
  input  wire logic [3:0] i_ch_on,
  input  wire logic       i_discharge,
  // Rail status
  output logic [3:0]      o_rail_up
);
  int level [4];

  // A rail left without discharge keeps its charge, so a missing discharge shows
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    for (int i = 0; i < 4; i++) begin
      if (!i_reset_n) level[i] <= 0;
      else if (i_ch_on[i] && level[i] < RAMP) level[i] <= level[i] + 1;
      else if (!i_ch_on[i] && i_discharge && level[i] > 0) level[i] <= level[i] - 1;
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) o_rail_up[i] = (level[i] == RAMP);
  end
endmodule

//--- bench/qbs_sequencer_bench.sv
// Self-checking bench for the quad buck power sequencer
`timescale 1ns/1ps
module qbs_sequencer_bench;
  import qbs_pkg::*;
  localparam int SC = 3;
  typedef struct { logic [3:0] ena; logic stg; } qbs_row_t;
  logic       i_clk_sys;
  logic       i_reset_n;
  logic       en;
  qbs_sense_t sense;
  qbs_cfg_t   cfg;
  logic [3:0] ch_on;
  logic [3:0] rail_up;
  logic [3:0] on_prev;
  logic       pg;
  logic       disch;
  logic       otw;
  logic       tsd;
  qbs_state_t st;
  qbs_state_t st_prev;
  int         n_errors;
  int         checks;
  int         cyc;
  int         t_seq;
  int         t_soff;
  int         t_on [4];
  int         t_off [4];
  qbs_row_t   rows [4] = '{'{4'hf, 1'b1}, '{4'hf, 1'b0}, '{4'h5, 1'b1}, '{4'ha, 1'b0}};

  qbs_sequencer dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_enable_sync_input_pin(en),
    .i_sense(sense), .i_cfg(cfg), .o_ch_on(ch_on), .o_power_good_output(pg), .o_discharge(disch),
    .o_overtemp_warning_flag(otw), .o_thermal_shutdown(tsd), .o_state(st));
  qbs_rail_model rails (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ch_on(ch_on),
    .i_discharge(disch), .o_rail_up(rail_up));

  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  // Cycle stamps of channel edges and state entries
  always @(posedge i_clk_sys) begin
    #1;
    cyc++;
    for (int i = 0; i < 4; i++) begin
      if (ch_on[i] === 1'b1 && on_prev[i] !== 1'b1) t_on[i] = cyc;
      if (ch_on[i] === 1'b0 && on_prev[i] === 1'b1) t_off[i] = cyc;
    end
    if (st === QBS_SEQ_ON && st_prev !== QBS_SEQ_ON) t_seq = cyc;
    if (st === QBS_SEQ_OFF && st_prev !== QBS_SEQ_OFF) t_soff = cyc;
    on_prev = ch_on;
    st_prev = st;
  end

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #10;
  endtask

  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wait_st(input qbs_state_t s);
    int k;
    for (k = 0; k < 300 && st !== s; k++) step(1);
    if (st !== s) begin
      n_errors++;
      $display("BAD state expected %0h seen %0h", s, st);
      complete_run();
    end
  endtask

  // Slot value 3 on channel 3 is clamped to 2
  function automatic int slot_of(input int i);
    return (i < 3) ? i : 2;
  endfunction

  initial begin
    i_reset_n = 1'b0;
    en = 1'b0;
    sense = '0;
    cfg = '0;
    cfg.ch_slot = {2'h3, 2'h2, 2'h1, 2'h0};
    cfg.slot_cycles = 24'(SC);
    step(16);
    chk("reset", {st, ch_on, pg, otw, tsd}, 9'h000);
    i_reset_n = 1'b1;
    step(1);
    chk("disch_off", disch, 1'b1);
    foreach (rows[r]) begin
      cfg.ch_enable = rows[r].ena;
      cfg.staged_off = rows[r].stg;
      en = 1'b1;
      wait_st(QBS_ON);
      chk("on", {ch_on, pg, disch}, {rows[r].ena, 2'b10});
      for (int i = 0; i < 4; i++) begin
        if (rows[r].ena[i]) chk("t_on", t_on[i] - t_seq, 1 + slot_of(i) * SC);
      end
      step(2);
      chk("rail", rail_up, rows[r].ena);
      en = 1'b0;
      wait_st(QBS_SEQ_OFF);
      chk("pg_first", {ch_on, pg, disch}, {rows[r].ena, 2'b01});
      // Pin raised again during a staged off sequence must be blanked
      en = rows[r].stg;
      wait_st(QBS_OFF);
      en = 1'b0;
      chk("off", ch_on, 4'h0);
      for (int i = 0; i < 4; i++) begin
        if (rows[r].ena[i]) chk("t_off", t_off[i] - t_soff, 1 + (rows[r].stg ? (2 - slot_of(i)) * SC : 0));
      end
      step(2);
      chk("drain", rail_up, 4'h0);
    end
    cfg.ch_enable = 4'hf;
    cfg.staged_off = 1'b1;
    en = 1'b1;
    wait_st(QBS_SEQ_ON);
    en = 1'b0;
    step(1);
    chk("abort", {st, ch_on}, {QBS_OFF, 4'h0});
    en = 1'b1;
    wait_st(QBS_ON);
    sense.uv_fall = 1'b1;
    step(1);
    chk("uv", {st, ch_on, pg}, {QBS_OFF, 5'h00});
    sense.uv_fall = 1'b0;
    wait_st(QBS_ON);
    sense.temp_120 = 1'b1;
    step(1);
    chk("warn", otw, 1'b1);
    sense.temp_140 = 1'b1;
    sense.temp_160 = 1'b1;
    step(1);
    chk("hot", {st, ch_on, tsd}, {QBS_OFF, 5'h01});
    sense.temp_160 = 1'b0;
    step(6);
    chk("hyst", {st, tsd}, {QBS_OFF, 1'b1});
    sense.temp_140 = 1'b0;
    wait_st(QBS_SEQ_ON);
    chk("latch", tsd, 1'b0);
    sense.temp_120 = 1'b0;
    step(1);
    chk("warn_clr", otw, 1'b0);
    en = 1'b0;
    wait_st(QBS_OFF);
    complete_run();
  end
endmodule
